/* File: rtl/ibsp_pkg.sv */
// Purpose: shared constants for the inbound bus slave port
// Assumes: single clock, synchronous active-low reset
// Notes:   request and response codes, register map, reset values
package ibsp_pkg;

  // request field widths
  localparam int CTRL_W = 8;
  localparam int ADDR_W = 32;
  localparam int TAG_W  = 6;
  localparam int URG_W  = 2;

  // request control codes
  localparam logic [CTRL_W-1:0] REQ_READ  = 8'h00;
  localparam logic [CTRL_W-1:0] REQ_WRITE = 8'h80;

  // response control codes, error flag ored in
  localparam logic [CTRL_W-1:0] RSP_READ  = 8'h00;
  localparam logic [CTRL_W-1:0] RSP_WRITE = 8'h10;
  localparam logic [CTRL_W-1:0] RSP_ERR   = 8'h01;

  // avalon register map, byte addresses
  localparam int                AV_AW       = 4;
  localparam logic [AV_AW-1:0]  OFS_CTRL    = 4'h0;
  localparam logic [AV_AW-1:0]  OFS_STATUS  = 4'h4;
  localparam logic [AV_AW-1:0]  OFS_ERRCNT  = 4'h8;
  localparam int                CTRL_EN_BIT = 0;
  localparam logic              EN_RESET    = 1'b1;
  localparam int                CNT_W       = 16;

  // port state machine, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } ibsp_state_t;

endpackage : ibsp_pkg

/* File: rtl/ibsp_lane_mem.sv */
// Purpose: local word store served by the inbound port
// Assumes: write and read index come from the same request
// Notes:   read is combinational, write per byte lane at clock edge
`timescale 1ns/1ps
`default_nettype none
module ibsp_lane_mem
  import ibsp_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  input  wire logic                     we_in,
  input  wire logic [$clog2(DEPTH)-1:0] idx_in,
  input  wire logic [W-1:0]             wdata_in,
  input  wire logic [W/8-1:0]           lanes_in,
  output logic      [W-1:0]             rdata_out
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] word;
  } ibsp_mem_t;

  ibsp_mem_t mem_q;
  ibsp_mem_t mem_d;

  // byte-lane merge into the addressed word
  always_comb begin
    mem_d = mem_q;
    if (we_in) begin
      for (int b = 0; b < W/8; b++) begin
        if (lanes_in[b]) begin
          mem_d.word[idx_in][b*8 +: 8] = wdata_in[b*8 +: 8];
        end
      end
    end
  end

  // storage clears at reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rdata_out = mem_q.word[idx_in];

endmodule // ibsp_lane_mem
`default_nettype wire

/* File: rtl/ibsp_port.sv */
// Purpose: inbound bus slave port answering tagged requests from a local store
// Assumes: master keeps request signals stable while unaccepted
// Notes:   one request in flight; accept drops while a response is pending
//
// Contract
// RQ1 - request signals are ignored whenever inbound request valid is low
// RQ2 - request moves only in a cycle with both valid and accept high
// RQ3 - master drives an 8-bit control field giving type and block size
// RQ4 - master gives a 32-bit address aligned to the transfer size
// RQ5 - write kinds carry their data on the request payload
// RQ6 - request and response payloads share one width: 32, 64 or 128
// RQ7 - one lane enable per payload byte marks valid bytes
// RQ8 - each response carries the 6-bit tag of its request
// RQ9 - tags may repeat and come in any order; nothing relies on them
// RQ10 - master drives 2-bit urgency, 0 lowest, 3 highest
// RQ11 - a processor master issues its requests at urgency 2
// RQ12 - response urgency equals the urgency of its request
// RQ13 - response valid qualifies all other response signals
// RQ14 - response moves only in a cycle with valid and master accept high
// RQ15 - 8-bit response control gives response type and error status
// RQ16 - valid without accept holds valid and qualified signals stable
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ibsp_port
  import ibsp_pkg::*;
#(
  parameter int PW    = 32, // one width for request and response payloads [RQ6]
  parameter int DEPTH = 16
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              inbound_request_valid_in,
  input  wire logic [CTRL_W-1:0] inbound_request_control_in,
  input  wire logic [ADDR_W-1:0] inbound_request_address_in,
  input  wire logic [PW-1:0]     inbound_request_payload_in,
  input  wire logic [PW/8-1:0]   inbound_lane_enables_in,
  input  wire logic [TAG_W-1:0]  inbound_request_tag_in,
  input  wire logic [URG_W-1:0]  inbound_request_urgency_in,
  output logic                   slave_accepts_request_out,
  output logic                   outbound_response_valid_out,
  output logic      [CTRL_W-1:0] outbound_response_control_out,
  output logic      [PW-1:0]     outbound_response_payload_out,
  output logic      [TAG_W-1:0]  outbound_response_tag_out,
  output logic      [URG_W-1:0]  outbound_response_urgency_out,
  input  wire logic              master_accepts_response_in,
  input  wire logic [AV_AW-1:0]  avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out
);

  localparam int ALSB = $clog2(PW/8);
  localparam int IDXW = $clog2(DEPTH);

  typedef struct packed {
    ibsp_state_t       state;
    logic              accept;
    logic              rvalid;
    logic [CTRL_W-1:0] rctrl;
    logic [PW-1:0]     rdata;
    logic [TAG_W-1:0]  rtag;
    logic [URG_W-1:0]  rurg;
    logic              enable;
    logic [CNT_W-1:0]  req_cnt;
    logic [CNT_W-1:0]  err_cnt;
    logic              wait_n;
    logic [31:0]       av_rdata;
  } ibsp_regs_t;

  ibsp_regs_t r_q;
  ibsp_regs_t r_d;

  logic            taken;
  logic            is_write;
  logic            bad;
  logic            mem_we;
  logic [IDXW-1:0] mem_idx;
  logic [PW-1:0]   mem_rdata;
  logic            av_go;

  // request decode: type, alignment and range checks
  always_comb begin
    taken    = inbound_request_valid_in && r_q.accept; // [RQ1] [RQ2]
    is_write = (inbound_request_control_in == REQ_WRITE);
    bad      = ((inbound_request_control_in != REQ_READ) && !is_write)
             || (inbound_request_address_in[ALSB-1:0] != '0)
             || (inbound_request_address_in[ADDR_W-1:ALSB+IDXW] != '0);
    mem_idx  = inbound_request_address_in[ALSB +: IDXW];
    mem_we   = taken && is_write && !bad;
    av_go    = (avs_read_in || avs_write_in) && r_q.wait_n;
  end

  // local store, lane-enabled writes
  ibsp_lane_mem #(
    .W     (PW),
    .DEPTH (DEPTH)
  ) u_mem (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .we_in     (mem_we),
    .idx_in    (mem_idx),
    .wdata_in  (inbound_request_payload_in),
    .lanes_in  (inbound_lane_enables_in),
    .rdata_out (mem_rdata)
  );

  // next-state logic for port and register slave
  always_comb begin
    r_d = r_q;
    case (r_q.state)
      ST_IDLE: begin
        if (taken) begin // [RQ2]
          r_d.state  = ST_RESP;
          r_d.accept = 1'b0;
          r_d.rvalid = 1'b1; // [RQ13]
          r_d.rtag   = inbound_request_tag_in; // [RQ8] [RQ9]
          r_d.rurg   = inbound_request_urgency_in; // [RQ12]
          r_d.rctrl  = (is_write ? RSP_WRITE : RSP_READ) | (bad ? RSP_ERR : '0); // [RQ15]
          r_d.rdata  = (is_write || bad) ? '0 : mem_rdata;
          r_d.req_cnt = r_q.req_cnt + 1'b1;
          if (bad) begin
            r_d.err_cnt = r_q.err_cnt + 1'b1;
          end
        end else begin
          r_d.accept = r_q.enable;
        end
      end
      ST_RESP: begin
        // hold response until the master takes it
        if (master_accepts_response_in) begin // [RQ14] [RQ16]
          r_d.state  = ST_IDLE;
          r_d.rvalid = 1'b0;
          r_d.accept = r_q.enable;
        end
      end
      default: begin
        r_d.state  = ST_IDLE;
        r_d.rvalid = 1'b0;
        r_d.accept = 1'b0;
      end
    endcase
    // avalon slave: one wait cycle, then one ready cycle
    r_d.wait_n = 1'b1;
    if (av_go) begin
      r_d.wait_n = 1'b0;
      if (avs_address_in == OFS_CTRL) begin
        r_d.av_rdata = {31'h0, r_q.enable};
      end else if (avs_address_in == OFS_STATUS) begin
        r_d.av_rdata = {r_q.req_cnt, 15'h0, r_q.rvalid};
      end else if (avs_address_in == OFS_ERRCNT) begin
        r_d.av_rdata = {16'h0, r_q.err_cnt};
      end else begin
        r_d.av_rdata = 32'h0;
      end
    end
    if (avs_write_in && !r_q.wait_n && avs_byteenable_in[0]) begin
      if (avs_address_in == OFS_CTRL) begin
        r_d.enable = avs_writedata_in[CTRL_EN_BIT];
        if (r_q.state == ST_IDLE && !taken) begin
          r_d.accept = avs_writedata_in[CTRL_EN_BIT];
        end
      end else if (avs_address_in == OFS_ERRCNT) begin
        r_d.err_cnt = '0;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r_q          <= '0;
      r_q.state    <= ST_IDLE;
      r_q.enable   <= EN_RESET;
      r_q.wait_n   <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flops
  assign slave_accepts_request_out     = r_q.accept;
  assign outbound_response_valid_out   = r_q.rvalid;
  assign outbound_response_control_out = r_q.rctrl;
  assign outbound_response_payload_out = r_q.rdata;
  assign outbound_response_tag_out     = r_q.rtag;
  assign outbound_response_urgency_out = r_q.rurg;
  assign avs_readdata_out              = r_q.av_rdata;
  assign avs_waitrequest_out           = r_q.wait_n;

  // assertion helpers
  sequence req_taken_s;
    inbound_request_valid_in && slave_accepts_request_out;
  endsequence

  sequence resp_stall_s;
    outbound_response_valid_out && !master_accepts_response_in;
  endsequence

  tag_echo_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RQ8]
    req_taken_s |=> outbound_response_valid_out
      && outbound_response_tag_out == $past(inbound_request_tag_in))
    else $error("response tag differs from request tag");

  urg_echo_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RQ12]
    req_taken_s |=> outbound_response_urgency_out == $past(inbound_request_urgency_in))
    else $error("response urgency differs from request urgency");

  resp_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RQ16]
    resp_stall_s |=> outbound_response_valid_out && $stable(outbound_response_tag_out)
      && $stable(outbound_response_control_out) && $stable(outbound_response_payload_out)
      && $stable(outbound_response_urgency_out))
    else $error("response changed before it was taken");

  resp_done_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RQ14]
    outbound_response_valid_out && master_accepts_response_in |=> !outbound_response_valid_out)
    else $error("response still valid after transfer");

  one_flight_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RQ2]
    slave_accepts_request_out |-> !outbound_response_valid_out)
    else $error("request accepted while response pending");

  no_ghost_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RQ1]
    !outbound_response_valid_out && !(inbound_request_valid_in && slave_accepts_request_out)
      |=> !outbound_response_valid_out)
    else $error("response without an accepted request");

  err_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RQ15]
    req_taken_s ##0 (inbound_request_address_in[ALSB-1:0] != '0)
      |=> outbound_response_control_out[0])
    else $error("misaligned request answered without error");

  wr_type_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RQ15]
    req_taken_s ##0 (inbound_request_control_in == REQ_WRITE)
      |=> (outbound_response_control_out & ~RSP_ERR) == RSP_WRITE)
    else $error("write answered with wrong response type");

  av_wait_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("register access not answered in one cycle");

endmodule // ibsp_port
`default_nettype wire

/* File: verification/ibsp_master_model.sv */
// Purpose: behavioural bus master for the inbound request port
// Assumes: one request in flight, fields held until taken
// Notes:   xfer issues one request and collects its response
`timescale 1ns/1ps
`default_nettype none
module ibsp_master_model
  import ibsp_pkg::*;
#(parameter int PW = 32) (
  input  wire logic              clk_in,
  output logic                   valid_out,
  output logic      [CTRL_W-1:0] ctrl_out,
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [PW-1:0]     data_out,
  output logic      [PW/8-1:0]   lanes_out,
  output logic      [TAG_W-1:0]  tag_out,
  output logic      [URG_W-1:0]  urg_out,
  input  wire logic              accept_in,
  input  wire logic              rvalid_in,
  input  wire logic [CTRL_W-1:0] rctrl_in,
  input  wire logic [PW-1:0]     rdata_in,
  input  wire logic [TAG_W-1:0]  rtag_in,
  input  wire logic [URG_W-1:0]  rurg_in,
  output logic                   rready_out
);
  // idle bus at time zero
  initial begin
    {valid_out, ctrl_out, addr_out, data_out, lanes_out, tag_out, urg_out, rready_out} = '0;
  end

  // one request, then its response after stall cycles of back-pressure
  task automatic xfer(input logic [CTRL_W-1:0] c, input logic [ADDR_W-1:0] a,
      input logic [PW-1:0] d, input logic [PW/8-1:0] l, input logic [TAG_W-1:0] t,
      input logic [URG_W-1:0] u, input int stall, output logic [CTRL_W-1:0] rc,
      output logic [PW-1:0] rd, output logic [TAG_W-1:0] rt,
      output logic [URG_W-1:0] ru, output bit ok);
    int n;
    ok = 1'b0;
    n  = 0;
    @(posedge clk_in);
    valid_out <= 1'b1;
    {ctrl_out, addr_out, data_out, lanes_out, tag_out, urg_out} <= {c, a, d, l, t, u};
    do begin // held until taken
      @(posedge clk_in);
      n++;
    end while (accept_in !== 1'b1 && n < 50);
    valid_out <= 1'b0;
    {ctrl_out, addr_out, data_out, lanes_out, tag_out, urg_out} <= ~{c, a, d, l, t, u};
    if (accept_in !== 1'b1) return;
    repeat (stall) @(posedge clk_in);
    rready_out <= 1'b1;
    n = 0;
    do begin // response moves on valid and ready together
      @(posedge clk_in);
      n++;
    end while (rvalid_in !== 1'b1 && n < 50);
    {rc, rd, rt, ru} = {rctrl_in, rdata_in, rtag_in, rurg_in};
    rready_out <= 1'b0;
    ok = (rvalid_in === 1'b1);
  endtask
endmodule // ibsp_master_model
`default_nettype wire

/* File: verification/inbound_bus_slave_port_tb.sv */
// Purpose: self-checking bench for the inbound bus slave port
// Assumes: PW of 32, sixteen-word store
// Notes:   requests through the master model, registers over avalon
`timescale 1ns/1ps
`default_nettype none
module inbound_bus_slave_port_tb
  import ibsp_pkg::*;
;
  logic              clk_in, nrst_in, rq_valid, accept, rs_valid, rs_ready;
  logic              av_rd, av_wr, av_wait;
  logic [CTRL_W-1:0] rq_ctrl, rs_ctrl, rc;
  logic [ADDR_W-1:0] rq_addr;
  logic [31:0]       rq_data, rs_data, av_wd, av_rdata, rd, v;
  logic [3:0]        rq_lanes, av_be;
  logic [TAG_W-1:0]  rq_tag, rs_tag, rt;
  logic [URG_W-1:0]  rq_urg, rs_urg, ru;
  logic [AV_AW-1:0]  av_addr;
  int                errors, samples_checked, nreq;

  ibsp_port dut (.clk_in(clk_in), .nrst_in(nrst_in), .inbound_request_valid_in(rq_valid),
    .inbound_request_control_in(rq_ctrl), .inbound_request_address_in(rq_addr),
    .inbound_request_payload_in(rq_data), .inbound_lane_enables_in(rq_lanes),
    .inbound_request_tag_in(rq_tag), .inbound_request_urgency_in(rq_urg),
    .slave_accepts_request_out(accept), .outbound_response_valid_out(rs_valid),
    .outbound_response_control_out(rs_ctrl), .outbound_response_payload_out(rs_data),
    .outbound_response_tag_out(rs_tag), .outbound_response_urgency_out(rs_urg),
    .master_accepts_response_in(rs_ready), .avs_address_in(av_addr), .avs_read_in(av_rd),
    .avs_write_in(av_wr), .avs_writedata_in(av_wd), .avs_byteenable_in(av_be),
    .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait));

  ibsp_master_model mdl (.clk_in(clk_in), .valid_out(rq_valid), .ctrl_out(rq_ctrl),
    .addr_out(rq_addr), .data_out(rq_data), .lanes_out(rq_lanes), .tag_out(rq_tag),
    .urg_out(rq_urg), .accept_in(accept), .rvalid_in(rs_valid), .rctrl_in(rs_ctrl),
    .rdata_in(rs_data), .rtag_in(rs_tag), .rurg_in(rs_urg), .rready_out(rs_ready));

  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic end_sim();
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic fail(input string what);
    errors++;
    $display("[ERR] %0t timeout %s", $time, what);
    end_sim();
  endtask

  // one compare for every result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // avalon access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [AV_AW-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    {av_rd, av_wr, av_addr, av_wd} <= {!wr, wr, a, wd};
    do begin
      @(posedge clk_in);
      n++;
    end while (av_wait !== 1'b0 && n < 50);
    if (n >= 50) fail("avalon");
    v = av_rdata;
    {av_rd, av_wr} <= 2'b00;
  endtask

  task automatic req(input logic [7:0] c, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] l, input logic [5:0] t, input logic [1:0] u, input int st);
    bit ok;
    mdl.xfer(c, a, d, l, t, u, st, rc, rd, rt, ru, ok);
    nreq++;
    if (!ok) fail("request");
  endtask

  task automatic s_store();
    req(REQ_WRITE, 32'h4, 32'h11223344, 4'hf, 6'h05, 2'h2, 0);
    chk(32'(rc), 32'(RSP_WRITE), "write code");
    chk(rd, 32'h0, "write payload");
    chk(32'(rt), 32'h05, "write tag");
    chk(32'(ru), 32'h2, "write urgency");
    req(REQ_WRITE, 32'h4, 32'haabbccdd, 4'h2, 6'h05, 2'h2, 1);
    req(REQ_READ, 32'h4, 32'h0, 4'hf, 6'h05, 2'h2, 4);
    chk(rd, 32'h1122cc44, "lane merge");
    chk(32'(rc), 32'(RSP_READ), "read code");
    chk(32'(rt), 32'h05, "repeated tag");
  endtask

  task automatic s_err();
    req(REQ_READ, 32'h2, 32'h0, 4'hf, 6'h11, 2'h1, 0);
    chk(32'(rc), 32'(RSP_READ | RSP_ERR), "misaligned");
    req(REQ_WRITE, 32'h40, 32'h5a5a5a5a, 4'hf, 6'h12, 2'h1, 0);
    chk(32'(rc), 32'(RSP_WRITE | RSP_ERR), "out of range");
    req(8'h40, 32'h0, 32'h0, 4'hf, 6'h13, 2'h1, 2);
    chk(32'(rc[0]), 32'h1, "bad code");
    av(1'b0, OFS_ERRCNT, 32'h0);
    chk(v, 32'h3, "error count");
    av(1'b1, OFS_ERRCNT, 32'h0);
    av(1'b0, OFS_ERRCNT, 32'h0);
    chk(v, 32'h0, "count clear");
  endtask

  task automatic s_urg();
    for (int u = 0; u < 4; u++) begin
      req(REQ_READ, 32'h4, 32'h0, 4'hf, 6'(8 * u + 7), 2'(u), u);
      chk(32'(ru), 32'(u), "urgency echo");
      chk(32'(rt), 32'(8 * u + 7), "tag echo");
      chk(rd, 32'h1122cc44, "reread");
    end
  endtask

  task automatic s_regs();
    av(1'b0, OFS_CTRL, 32'h0);
    chk(v, 32'(EN_RESET), "ctrl reset");
    av(1'b0, 4'hc, 32'h0);
    chk(v, 32'h0, "unmapped");
    av(1'b0, OFS_STATUS, 32'h0);
    chk(v & 32'hffff0001, {16'(nreq), 16'h0}, "status");
    // a write without lane 0 must leave the enable alone
    av_be <= 4'he;
    av(1'b1, OFS_CTRL, 32'h0);
    av_be <= 4'hf;
    av(1'b0, OFS_CTRL, 32'h0);
    chk(v, 32'h1, "lane-masked write");
    av(1'b1, OFS_CTRL, 32'h0);
    repeat (4) @(posedge clk_in);
    chk(32'(accept), 32'h0, "disabled");
    av(1'b1, OFS_CTRL, 32'h1);
    req(REQ_READ, 32'h4, 32'h0, 4'hf, 6'h3f, 2'h3, 0);
    chk(rd, 32'h1122cc44, "re-enabled");
  endtask

  // reset, then each scenario in turn
  initial begin
    {errors, samples_checked, nreq} = '0;
    {nrst_in, av_rd, av_wr, av_addr, av_wd} = '0;
    av_be = 4'hf;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    s_store();
    s_err();
    s_urg();
    s_regs();
    end_sim();
  end
endmodule // inbound_bus_slave_port_tb
`default_nettype wire
